// ===== bench/brf_assertions.sv
// Checker for the link between the sample buffer read port and its controller.
`timescale 1ns/1ps
module brf_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [2:0]  sel,
    input wire logic        upper_byte_read_enable_n,
    input wire logic        lower_byte_read_enable_n,
    input wire logic [7:0]  upper_output_byte,
    input wire logic [7:0]  lower_output_byte,
    input wire logic        depth_interrupt_out_n,
    input wire logic        cw_strobe,
    input wire logic [7:0]  cw_addr,
    input wire logic [31:0] cw_data,
    input wire logic        sample_valid,
    input wire logic [2:0]  fifo_depth_ff,
    input wire logic        fifo_full_ff,
    input wire logic        sample_dropped_ff
);
    logic       mode_ff;
    logic       route_ff;
    logic [2:0] thr_ff;
    wire        irq_n = depth_interrupt_out_n;
    wire        quiet = !cw_strobe && lower_byte_read_enable_n;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies of the control words, so the checks know the mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= 1'b0;
            thr_ff  <= 3'h0;
        end else if (cw_strobe && cw_addr == brf_pkg::CW_FIFO) begin
            mode_ff <= cw_data[15];
            thr_ff  <= cw_data[14:12];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_ff <= 1'b0;
        end else if (cw_strobe && cw_addr == brf_pkg::CW_ROUTE) begin
            route_ff <= cw_data[24] && !cw_data[25];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_irq_len; $fell(irq_n) |-> (!irq_n) [*8]; endproperty
    a_irq_len: assert property (p_irq_len) else $error("interrupt pulse too short");
    property p_irq_fire; mode_ff && fifo_depth_ff > thr_ff && $past(fifo_depth_ff) <= thr_ff |-> !irq_n; endproperty
    a_irq_fire: assert property (p_irq_fire) else $error("no interrupt at threshold");
    property p_drop; sample_valid && fifo_full_ff && quiet |=> sample_dropped_ff && fifo_depth_ff == 3'h7; endproperty
    a_drop: assert property (p_drop) else $error("write while full");
    property p_empty; fifo_depth_ff == 3'h1 && !sample_valid |=> fifo_depth_ff == 3'h1; endproperty
    a_empty: assert property (p_empty) else $error("empty buffer advanced");
    property p_write; sample_valid && !fifo_full_ff && quiet |=> fifo_depth_ff == $past(fifo_depth_ff) + 3'h1; endproperty
    a_write: assert property (p_write) else $error("depth not raised by write");
    property p_ptr_rst; cw_strobe && cw_addr == brf_pkg::CW_PTR_RESET |=> fifo_depth_ff == 3'h1 && !fifo_full_ff;
    endproperty
    a_ptr_rst: assert property (p_ptr_rst) else $error("pointer reset failed");
    property p_status;
        (sel == 3'h6 && !upper_byte_read_enable_n && !lower_byte_read_enable_n) [*3]
        |-> lower_output_byte == 8'h00 && upper_output_byte[1:0] == 2'h0;
    endproperty
    a_status: assert property (p_status) else $error("status low bits not zero");
    property p_port_adv;
        $fell(lower_byte_read_enable_n) && sel == 3'h7 && route_ff && fifo_depth_ff != 3'h1 && !sample_valid
        && !cw_strobe |=> fifo_depth_ff == $past(fifo_depth_ff) - 3'h1;
    endproperty
    a_port_adv: assert property (p_port_adv) else $error("port advance failed");
    property p_adv_wait;
        ($fell(lower_byte_read_enable_n) && sel == 3'h7) || (cw_strobe && cw_addr == brf_pkg::CW_ADVANCE)
        |=> (!$fell(lower_byte_read_enable_n)) [*4];
    endproperty
    a_adv_wait: assert property (p_adv_wait) else $error("read too soon after advance");
    c_irq: cover property ($fell(irq_n));
    c_drop: cover property (sample_dropped_ff);
    c_adv: cover property ($fell(lower_byte_read_enable_n) && sel == 3'h7);
endmodule

// ===== bench/tb.sv
// Self-checking bench for the sample buffer read port and its APB controller.
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, sample_valid, pready_ff, pslverr_ff, fifo_full_ff, err;
    logic        sample_dropped_ff;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_ff, rd;
    logic [2:0]  fifo_depth_ff;
    logic [15:0] smp [5];
    int          n_fail, comparisons, k_next;
    brf_if link ();
    brf_device brf_device_i (.pclk(pclk), .presetn(presetn), .port(link), .sample_valid(sample_valid),
        .sample_i(smp[0]), .sample_q(smp[1]), .sample_mag(smp[2]), .sample_phase(smp[3]), .sample_freq(smp[4]),
        .fifo_depth_ff(fifo_depth_ff), .fifo_full_ff(fifo_full_ff), .sample_dropped_ff(sample_dropped_ff));
    brf_host brf_host_i (.pclk(pclk), .presetn(presetn), .port(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff));
    brf_assertions brf_assertions_i (.pclk(pclk), .presetn(presetn), .sel(link.sel),
        .upper_byte_read_enable_n(link.upper_byte_read_enable_n),
        .lower_byte_read_enable_n(link.lower_byte_read_enable_n), .upper_output_byte(link.upper_output_byte),
        .lower_output_byte(link.lower_output_byte), .depth_interrupt_out_n(link.depth_interrupt_out_n),
        .cw_strobe(link.cw_strobe), .cw_addr(link.cw_addr), .cw_data(link.cw_data), .sample_valid(sample_valid),
        .fifo_depth_ff(fifo_depth_ff), .fifo_full_ff(fifo_full_ff), .sample_dropped_ff(sample_dropped_ff));
    ////////////////////////////////////////////////////////////////////////////
    // Each field of each sample set is distinct, so a wrong set or field shows.
    function automatic logic [15:0] word_of(input int s, input int k);
        return {4'(s + 1), 4'(k), 8'h5A ^ 8'(k)};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here: a slave that never answers is caught by the watchdog.
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'b1);
        rd  = prdata_ff;
        err = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Polling busy is the only safe pacing: the controller ignores commands while busy.
    task automatic cmd(input logic [31:0] c);
        apb(1'b1, brf_pkg::REG_CMD, c);
        do begin
            apb(1'b0, brf_pkg::REG_STATUS, 32'h0000_0000);
        end while (rd[brf_pkg::STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic cw(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, brf_pkg::REG_CW_ADDR, {24'h00_0000, a});
        apb(1'b1, brf_pkg::REG_CW_DATA, d);
        cmd(32'h0000_0100);
    endtask
    task automatic push(input int cnt);
        for (int j = 0; j < cnt; j++) begin
            @(posedge pclk);
            sample_valid <= 1'b1;
            for (int s = 0; s < 5; s++) smp[s] <= word_of(s, k_next);
            k_next++;
        end
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, sample_valid, paddr, pwdata} = '0;
        for (int s = 0; s < 5; s++) smp[s] = 16'h0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cw(brf_pkg::CW_ROUTE, 32'h0100_0000);
        cw(brf_pkg::CW_FIFO, 32'h0000_A000);
        cmd(32'h0000_0006);
        chk(rd[15:0], 16'h3400);
        cmd(32'h0000_0007);
        cmd(32'h0000_0006);
        chk(rd[15:0], 16'h3400);
        push(3);
        apb(1'b0, brf_pkg::REG_STATUS, 32'h0000_0000);
        chk(rd[brf_pkg::STAT_INT_BIT], 1'b1);
        cmd(32'h0000_0006);
        chk(rd[15:0], 16'h8000);
        cmd(32'h0000_0007);
        for (int s = 0; s < 6; s++) begin
            cmd(32'(s));
            chk(rd[15:0], (s < 5) ? word_of(s, 0) : 16'h0000);
        end
        cmd(32'h0000_0006);
        chk(rd[15:0], 16'h6000);
        push(5);
        chk(fifo_depth_ff, 3'h7);
        chk(fifo_full_ff, 1'b1);
        cmd(32'h0000_0006);
        chk(rd[15:0], 16'hE800);
        cmd(32'h0000_0007);
        cmd(32'h0000_0000);
        chk(rd[15:0], word_of(0, 1));
        cw(brf_pkg::CW_ROUTE, 32'h0000_0000);
        cw(brf_pkg::CW_ADVANCE, 32'h0000_0000);
        chk(fifo_depth_ff, 3'h5);
        cw(brf_pkg::CW_PTR_RESET, 32'h0000_0000);
        chk(fifo_depth_ff, 3'h1);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(err, 1'b1);
        give_verdict();
    end
endmodule

// ===== inc/brf_if.sv
// Link between the sample buffer read port and the controller that reads it.
`timescale 1ns/1ps
interface brf_if;
    logic [2:0]  sel;
    logic        upper_byte_read_enable_n;
    logic        lower_byte_read_enable_n;
    logic [7:0]  upper_output_byte;
    logic [7:0]  lower_output_byte;
    logic        depth_interrupt_out_n;
    logic        cw_strobe;
    logic [7:0]  cw_addr;
    logic [31:0] cw_data;

    modport device (
        input  sel,
        input  upper_byte_read_enable_n,
        input  lower_byte_read_enable_n,
        output upper_output_byte,
        output lower_output_byte,
        output depth_interrupt_out_n,
        input  cw_strobe,
        input  cw_addr,
        input  cw_data
    );

    modport host (
        output sel,
        output upper_byte_read_enable_n,
        output lower_byte_read_enable_n,
        input  upper_output_byte,
        input  lower_output_byte,
        input  depth_interrupt_out_n,
        output cw_strobe,
        output cw_addr,
        output cw_data
    );
endinterface

// ===== inc/brf_pkg.sv
// Shared constants for the buffer RAM FIFO read port and its host controller.
package brf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          WORD_W        = 16;
    localparam int          WORDS_PER_SET = 5;
    localparam int          SET_W         = 80;
    localparam int          SETS          = 8;
    localparam int          PTR_W         = 3;
    localparam int          SEL_W         = 3;
    localparam int          CWA_W         = 8;
    localparam int          CWD_W         = 32;

    localparam logic [2:0]  SEL_I         = 3'h0;
    localparam logic [2:0]  SEL_Q         = 3'h1;
    localparam logic [2:0]  SEL_MAG       = 3'h2;
    localparam logic [2:0]  SEL_PHASE     = 3'h3;
    localparam logic [2:0]  SEL_FREQ      = 3'h4;
    localparam logic [2:0]  SEL_UNUSED    = 3'h5;
    localparam logic [2:0]  SEL_STATUS    = 3'h6;
    localparam logic [2:0]  SEL_ADVANCE   = 3'h7;

    localparam logic [7:0]  CW_ROUTE      = 8'h14;
    localparam logic [7:0]  CW_FIFO       = 8'h15;
    localparam logic [7:0]  CW_PTR_RESET  = 8'h16;
    localparam logic [7:0]  CW_ADVANCE    = 8'h17;

    localparam int          CW20_ROUTE16  = 24;
    localparam int          CW20_PORT_OFF = 25;
    localparam int          CW21_FIFO_EN  = 15;
    localparam int          CW21_THR_LSB  = 12;

    localparam logic [2:0]  WR_PTR_RST    = 3'h0;
    localparam logic [2:0]  RD_PTR_RST    = 3'h7;
    localparam logic [2:0]  DIFF_EMPTY    = 3'h1;
    localparam logic [2:0]  DIFF_FULL     = 3'h7;

    localparam int          ST_DEPTH_LSB  = 5;
    localparam int          ST_EMPTY      = 4;
    localparam int          ST_FULL       = 3;
    localparam int          ST_READY_N    = 2;

    localparam logic [3:0]  INT_PULSE_CYC = 4'h8;
    localparam logic [2:0]  ADV_WAIT_CYC  = 3'h4;
    localparam logic [2:0]  READ_WAIT_CYC = 3'h3;

    localparam int          APB_AW        = 8;
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_CW_ADDR   = 8'h04;
    localparam logic [7:0]  REG_CW_DATA   = 8'h08;
    localparam logic [7:0]  REG_STATUS    = 8'h0C;
    localparam int          CMD_KIND_BIT  = 8;
    localparam int          STAT_BUSY_BIT = 16;
    localparam int          STAT_INT_BIT  = 17;

    typedef enum logic [2:0] {
        BRF_IDLE   = 3'b000,
        BRF_SETUP  = 3'b001,
        BRF_STROBE = 3'b010,
        BRF_HOLD   = 3'b011,
        BRF_CWRITE = 3'b100
    } brf_host_state_type;

endpackage

// ===== src/brf_device.sv
// Read side of the eight-set sample buffer: pointers, status, interrupt, 16-bit port.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - Host sets route word bits before port reads.
// - Select code picks word, status or advance.
// - Select seven with lower enable advances.
// - Upper byte on upper bus, lower on lower.
// - Only falling lower enable fetches new data.
// - Status bits seven to five show depth.
// - Status bit four empty, three full.
// - Status bit two active-low threshold ready.
// - Status low bits and lower byte zero.
// - Pointers never equal; advance before first read.
// - Reader waits four cycles after advance.
// - Depth is write minus read, modulo eight.
// - Full stops writes; unread data kept.
// - Empty ignores read pointer advance requests.
// - Reset puts write zero, read seven.
// - Interrupt when depth passes the threshold.
// - Interrupt held low at least eight cycles.
// - Early reader tracks count through status.
// - Host clears route bit for byte interface.
// - Control word 23 write advances read pointer.
// - Control word 22 write resets both pointers.
// - Eight sets of five sixteen-bit words.
// - Word 21 holds mode and threshold.
module brf_device #(
    parameter int SETS = brf_pkg::SETS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    brf_if.device            port,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_i,
    input  wire logic [15:0] sample_q,
    input  wire logic [15:0] sample_mag,
    input  wire logic [15:0] sample_phase,
    input  wire logic [15:0] sample_freq,
    output logic      [2:0]  fifo_depth_ff,
    output logic             fifo_full_ff,
    output logic             sample_dropped_ff
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]  wr_ptr_ff;
    logic [2:0]  rd_ptr_ff;
    logic        route16_ff;
    logic        port_off_ff;
    logic        fifo_mode_ff;
    logic [2:0]  thr_ff;
    logic        oe_b_prev_ff;
    logic [15:0] word_ff;
    logic [7:0]  upper_ff;
    logic [7:0]  lower_ff;
    logic [3:0]  int_cnt_ff;
    logic        int_n_ff;

    logic [79:0] ram_rd;
    logic [2:0]  diff;
    logic        empty;
    logic        full;
    logic        ready_n;
    logic        port_on;
    logic        oe_b_fall;
    logic        adv_req;
    logic        do_write;
    logic        do_adv;
    logic        ptr_reset;
    logic [2:0]  nxt_wr_ptr;
    logic [2:0]  nxt_rd_ptr;
    logic [2:0]  nxt_diff;
    logic        int_fire;
    logic [3:0]  nxt_int_cnt;
    logic [15:0] status_word;

    // Pick one 16-bit word of a sample set; codes above frequency read as zero.
    function automatic logic [15:0] pick_word(input logic [79:0] row, input logic [2:0] s);
        logic [15:0] w;
        w = '0;
        case (s)
            brf_pkg::SEL_I:     w = row[15:0];
            brf_pkg::SEL_Q:     w = row[31:16];
            brf_pkg::SEL_MAG:   w = row[47:32];
            brf_pkg::SEL_PHASE: w = row[63:48];
            brf_pkg::SEL_FREQ:  w = row[79:64];
            default:            w = '0;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sample store, written at the write pointer and read at the read pointer.
    brf_ram #(
        .DEPTH  (SETS),
        .WIDTH  (brf_pkg::SET_W),
        .ADDR_W (brf_pkg::PTR_W)
    ) u_ram (
        .pclk    (pclk),
        .wr_en   (do_write),
        .wr_addr (wr_ptr_ff),
        .wr_data ({sample_freq, sample_phase, sample_mag, sample_q, sample_i}),
        .rd_addr (rd_ptr_ff),
        .rd_data (ram_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The read pointer sits one behind the oldest unread set, so an empty buffer has a
    // difference of one and the two pointers can never meet.
    assign diff      = wr_ptr_ff - rd_ptr_ff;
    assign empty     = (diff == brf_pkg::DIFF_EMPTY);
    assign full      = (diff == brf_pkg::DIFF_FULL);
    assign ready_n   = fifo_mode_ff ? !(diff > thr_ff) : !full;
    assign port_on   = route16_ff && !port_off_ff;
    assign oe_b_fall = oe_b_prev_ff && !port.lower_byte_read_enable_n;
    assign ptr_reset = port.cw_strobe && (port.cw_addr == brf_pkg::CW_PTR_RESET);
    // Besides a pointer reset, only the advance code or the advance control word move the read pointer.
    assign adv_req   = (port_on && oe_b_fall && (port.sel == brf_pkg::SEL_ADVANCE))
                     || (!route16_ff && port.cw_strobe && (port.cw_addr == brf_pkg::CW_ADVANCE));
    assign do_write  = sample_valid && !full;
    assign do_adv    = adv_req && !empty;
    assign nxt_wr_ptr = ptr_reset ? brf_pkg::WR_PTR_RST : (do_write ? wr_ptr_ff + 3'h1 : wr_ptr_ff);
    assign nxt_rd_ptr = ptr_reset ? brf_pkg::RD_PTR_RST : (do_adv ? rd_ptr_ff + 3'h1 : rd_ptr_ff);
    assign nxt_diff  = nxt_wr_ptr - nxt_rd_ptr;
    // Firing on the write edge only means a read that drops the depth and a later write
    // that lifts it again re-arms the interrupt; readers that keep the depth above the threshold avoid this.
    assign int_fire  = fifo_mode_ff && do_write && !ptr_reset
                     && (nxt_diff > thr_ff) && !(diff > thr_ff);
    assign nxt_int_cnt = int_fire ? brf_pkg::INT_PULSE_CYC
                       : ((int_cnt_ff != 4'h0) ? int_cnt_ff - 4'h1 : 4'h0);
    assign status_word = {diff, empty, full, ready_n, 2'b00, 8'h00};

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= brf_pkg::WR_PTR_RST;
            rd_ptr_ff <= brf_pkg::RD_PTR_RST;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // Control words arrive whole; only the bits this block uses are kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route16_ff   <= 1'b0;
            port_off_ff  <= 1'b0;
            fifo_mode_ff <= 1'b0;
            thr_ff       <= 3'h0;
        end else if (port.cw_strobe) begin
            if (port.cw_addr == brf_pkg::CW_ROUTE) begin
                route16_ff  <= port.cw_data[brf_pkg::CW20_ROUTE16];
                port_off_ff <= port.cw_data[brf_pkg::CW20_PORT_OFF];
            end
            if (port.cw_addr == brf_pkg::CW_FIFO) begin
                fifo_mode_ff <= port.cw_data[brf_pkg::CW21_FIFO_EN];
                thr_ff       <= port.cw_data[brf_pkg::CW21_THR_LSB +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_b_prev_ff <= 1'b1;
        end else begin
            oe_b_prev_ff <= port.lower_byte_read_enable_n;
        end
    end

    // A word is fetched once per falling lower enable and then held.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_ff <= '0;
        end else if (port_on && oe_b_fall) begin
            word_ff <= (port.sel == brf_pkg::SEL_STATUS) ? status_word
                     : pick_word(ram_rd, port.sel);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_ff <= '0;
            lower_ff <= '0;
        end else if (port_on && !port.upper_byte_read_enable_n && !port.lower_byte_read_enable_n) begin
            upper_ff <= word_ff[15:8];
            lower_ff <= word_ff[7:0];
        end else begin
            upper_ff <= '0;
            lower_ff <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_cnt_ff <= 4'h0;
            int_n_ff   <= 1'b1;
        end else begin
            int_cnt_ff <= nxt_int_cnt;
            int_n_ff   <= (nxt_int_cnt == 4'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_depth_ff     <= brf_pkg::WR_PTR_RST - brf_pkg::RD_PTR_RST;
            fifo_full_ff      <= 1'b0;
            sample_dropped_ff <= 1'b0;
        end else begin
            fifo_depth_ff     <= nxt_diff;
            fifo_full_ff      <= (nxt_diff == brf_pkg::DIFF_FULL);
            sample_dropped_ff <= sample_valid && full;
        end
    end

    assign port.upper_output_byte     = upper_ff;
    assign port.lower_output_byte     = lower_ff;
    assign port.depth_interrupt_out_n = int_n_ff;
endmodule

// ===== src/brf_host.sv
// Controller that reads the sample buffer port and writes control words, driven over APB.
`timescale 1ns/1ps
module brf_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    brf_if.host              port,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff
);
    ////////////////////////////////////////////////////////////////////////////
    brf_pkg::brf_host_state_type state_ff;
    logic [2:0]  sel_ff;
    logic        oe_ff_n;
    logic        cw_strobe_ff;
    logic [7:0]  cw_addr_ff;
    logic [31:0] cw_data_ff;
    logic [15:0] last_word_ff;
    logic [2:0]  cnt_ff;

    logic        apb_done;
    logic        wr_cmd;
    logic        mapped;

    assign apb_done = psel && penable && pready_ff;
    assign wr_cmd   = apb_done && pwrite && (paddr == brf_pkg::REG_CMD) && (state_ff == brf_pkg::BRF_IDLE);
    assign mapped   = (paddr == brf_pkg::REG_CMD) || (paddr == brf_pkg::REG_CW_ADDR)
                   || (paddr == brf_pkg::REG_CW_DATA) || (paddr == brf_pkg::REG_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // Zero-wait slave: the answer is prepared in the setup cycle and stands for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else if (psel && !penable) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !mapped;
            case (paddr)
                brf_pkg::REG_CW_ADDR: prdata_ff <= {24'h0000_00, cw_addr_ff};
                brf_pkg::REG_CW_DATA: prdata_ff <= cw_data_ff;
                // Status shows the last port word and the live interrupt level.
                brf_pkg::REG_STATUS:  prdata_ff <= {14'h0000, !port.depth_interrupt_out_n,
                                                    state_ff != brf_pkg::BRF_IDLE, last_word_ff};
                default:              prdata_ff <= '0;
            endcase
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cw_addr_ff <= '0;
            cw_data_ff <= '0;
        end else if (apb_done && pwrite) begin
            if (paddr == brf_pkg::REG_CW_ADDR) begin
                cw_addr_ff <= pwdata[7:0];
            end
            if (paddr == brf_pkg::REG_CW_DATA) begin
                cw_data_ff <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commands given while busy are dropped; software polls the busy bit first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= brf_pkg::BRF_IDLE;
            sel_ff       <= brf_pkg::SEL_STATUS;
            oe_ff_n      <= 1'b1;
            cw_strobe_ff <= 1'b0;
            cnt_ff       <= 3'h0;
            last_word_ff <= '0;
        end else begin
            cw_strobe_ff <= 1'b0;
            case (state_ff)
                brf_pkg::BRF_IDLE: begin
                    if (wr_cmd && pwdata[brf_pkg::CMD_KIND_BIT]) begin
                        // Routing bits in control word 20 are software's to set here.
                        cw_strobe_ff <= 1'b1;
                        state_ff     <= brf_pkg::BRF_CWRITE;
                    end else if (wr_cmd) begin
                        sel_ff   <= pwdata[2:0];
                        state_ff <= brf_pkg::BRF_SETUP;
                    end
                end
                brf_pkg::BRF_SETUP: begin
                    oe_ff_n  <= 1'b0;
                    cnt_ff   <= 3'h0;
                    state_ff <= brf_pkg::BRF_STROBE;
                end
                brf_pkg::BRF_STROBE: begin
                    if (cnt_ff == brf_pkg::READ_WAIT_CYC - 3'h1) begin
                        last_word_ff <= {port.upper_output_byte, port.lower_output_byte};
                        oe_ff_n      <= 1'b1;
                        cnt_ff       <= 3'h0;
                        state_ff     <= (sel_ff == brf_pkg::SEL_ADVANCE) ? brf_pkg::BRF_HOLD : brf_pkg::BRF_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 3'h1;
                    end
                end
                brf_pkg::BRF_CWRITE: begin
                    cnt_ff   <= 3'h0;
                    state_ff <= (cw_addr_ff == brf_pkg::CW_ADVANCE) ? brf_pkg::BRF_HOLD : brf_pkg::BRF_IDLE;
                end
                brf_pkg::BRF_HOLD: begin
                    if (cnt_ff == brf_pkg::ADV_WAIT_CYC - 3'h1) begin
                        state_ff <= brf_pkg::BRF_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 3'h1;
                    end
                end
                default: begin
                    state_ff <= brf_pkg::BRF_IDLE;
                end
            endcase
        end
    end

    assign port.sel                      = sel_ff;
    assign port.upper_byte_read_enable_n = oe_ff_n;
    assign port.lower_byte_read_enable_n = oe_ff_n;
    assign port.cw_strobe                = cw_strobe_ff;
    assign port.cw_addr                  = cw_addr_ff;
    assign port.cw_data                  = cw_data_ff;
endmodule

// ===== src/brf_ram.sv
// Sample-set store: one write port and one asynchronous read port.
`timescale 1ns/1ps
module brf_ram #(
    parameter int DEPTH  = brf_pkg::SETS,
    parameter int WIDTH  = brf_pkg::SET_W,
    parameter int ADDR_W = brf_pkg::PTR_W
) (
    input  wire logic              pclk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);
    // No reset on the array: contents are only meaningful once written.
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule
